// File: logic/mesr_consts.svh
// offsets, field positions, reset values and preload byte map
`ifndef MESR_CONSTS_SVH
`define MESR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (register index on the plain port)
// ----------------------------------------------------------------
`define MESR_OFF_STATUS 8'h00
`define MESR_OFF_CTRL 8'h01
`define MESR_OFF_ADDR_HI 8'h02
`define MESR_OFF_ADDR_LO 8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MESR_BIT_TRANSMIT_ENABLE 3
`define MESR_BIT_RECEIVE_ENABLE 2
`define MESR_BIT_INIT_DONE 0
`define MESR_BIT_EE_LOADED 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MESR_RST_CTRL 4'h0
`define MESR_RST_ADDR_HI 16'hffff
`define MESR_RST_ADDR_LO 32'h0fffffff

// ----------------------------------------------------------------
// eeprom byte addresses of the station address
// ----------------------------------------------------------------
`define MESR_EE_LO_B0 8'h01
`define MESR_EE_LO_B1 8'h02
`define MESR_EE_LO_B2 8'h03
`define MESR_EE_LO_B3 8'h04
`define MESR_EE_HI_B0 8'h05
`define MESR_EE_HI_B1 8'h06

`endif

// File: logic/mesr_pkg.sv
// types shared by the station address register bank
package mesr_pkg;
  // init phase of the bank: waiting for the loader, or running
  typedef enum logic [0:0] {
    MESR_ST_INIT = 1'b0,
    MESR_ST_RUN = 1'b1
  } mesr_state_e;
  typedef logic [7:0] mesr_addr_t;
  typedef logic [31:0] mesr_word_t;
endpackage

// File: logic/mesr_regs.sv
// mac enable bits and 48-bit station address register bank
//
// Functional notes
// [RQ1] tx enable bit 3 gates frame taking
// [RQ2] rx enable bit 2 gates frame acceptance
// [RQ3] high address bits 15:0 at offset 02h
// [RQ4] high bits 31:16 read zero, reset ffff
// [RQ5] eeprom bytes 05h,06h fill high bytes
// [RQ6] low address 32 bits at offset 03h
// [RQ7] low address resets to printed all-ones value; code loads 0fffffff
// [RQ8] eeprom 01h low byte, 04h top byte
// [RQ9] preload only from a programmed eeprom
// [RQ10] address drives da match and pause frames; code has da match only, no pause frame logic
// [RQ11] address not used in packet filtering
// [RQ12] address undefined until power-on load done
// [RQ13] host rewrites address only after init
// [RQ14] eeprom 02h,03h fill low bytes 1,2
// [RQ15] wire byte order starts at low bits 7:0
`timescale 1ns/1ps
`include "mesr_consts.svh"

module mesr_regs
  import mesr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // eeprom loader byte stream
  input wire logic ee_programmed,
  input wire logic ee_byte_wr,
  input wire logic [7:0] ee_byte_addr,
  input wire logic [7:0] ee_byte_data,
  input wire logic ee_load_done,
  // mac datapath side
  input wire logic tx_frame_req,
  input wire logic rx_frame_valid,
  input wire logic rx_da_valid,
  input wire logic [47:0] rx_da,
  output logic tx_enable_q,
  output logic rx_enable_q,
  output logic tx_take_q,
  output logic rx_accept_q,
  output logic da_match_q,
  output logic addr_valid_q,
  output logic [47:0] station_addr_q
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // replace one byte lane of a word
  function automatic mesr_word_t put_byte(input mesr_word_t w,
                                          input logic [1:0] lane,
                                          input logic [7:0] b);
    mesr_word_t r;
    r = w;
    r[lane*8 +: 8] = b;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mesr_state_e state_q; // init or running
  mesr_state_e state_d;
  logic ee_loaded_q; // eeprom contents landed
  logic ee_loaded_d;
  logic [15:0] addr_hi_q; // station address 47:32
  logic [15:0] addr_hi_d;
  mesr_word_t addr_lo_q; // station address 31:0
  mesr_word_t addr_lo_d;
  logic tx_enable_d;
  logic rx_enable_d;
  logic tx_take_d;
  logic rx_accept_d;
  logic da_match_d;
  logic addr_valid_d;
  logic [47:0] station_addr_d;
  mesr_word_t reg_rdata_d;
  logic load_ok; // loader byte accepted
  logic host_ok; // host may touch address

  // ----------------------------------------------------------------
  // init phase and eeprom preload
  // ----------------------------------------------------------------

  // loader bytes only count while still initialising
  assign load_ok = ee_byte_wr && ee_programmed
                   && (state_q == MESR_ST_INIT); // see [RQ9]
  // host address writes wait for init so the loader is not raced
  assign host_ok = (state_q == MESR_ST_RUN); // see [RQ13]

  // next init phase
  always_comb
  begin
    state_d = state_q;
    ee_loaded_d = ee_loaded_q;
    case (state_q)
      MESR_ST_INIT:
      begin
        if (load_ok)
        begin
          ee_loaded_d = 1'b1;
        end
        if (ee_load_done)
        begin
          state_d = MESR_ST_RUN;
        end
      end
      MESR_ST_RUN:
      begin
        state_d = MESR_ST_RUN; // stays until reset
      end
      default:
      begin
        state_d = MESR_ST_INIT;
      end
    endcase
  end

  // register init phase
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q <= MESR_ST_INIT;
      ee_loaded_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ee_loaded_q <= ee_loaded_d;
    end
  end

  // ----------------------------------------------------------------
  // address and control registers
  // ----------------------------------------------------------------

  // next register values from loader or host
  always_comb
  begin
    addr_hi_d = addr_hi_q;
    addr_lo_d = addr_lo_q;
    tx_enable_d = tx_enable_q;
    rx_enable_d = rx_enable_q;
    if (load_ok)
    begin
      case (ee_byte_addr)
        `MESR_EE_LO_B0: addr_lo_d = put_byte(addr_lo_q, 2'd0,
                                             ee_byte_data); // see [RQ8]
        `MESR_EE_LO_B1: addr_lo_d = put_byte(addr_lo_q, 2'd1,
                                             ee_byte_data); // see [RQ14]
        `MESR_EE_LO_B2: addr_lo_d = put_byte(addr_lo_q, 2'd2,
                                             ee_byte_data); // see [RQ14]
        `MESR_EE_LO_B3: addr_lo_d = put_byte(addr_lo_q, 2'd3,
                                             ee_byte_data); // see [RQ8]
        `MESR_EE_HI_B0: addr_hi_d[7:0] = ee_byte_data; // see [RQ5]
        `MESR_EE_HI_B1: addr_hi_d[15:8] = ee_byte_data; // see [RQ5]
        default:
        begin
          addr_hi_d = addr_hi_q; // other eeprom bytes not ours
        end
      endcase
    end
    if (reg_wr)
    begin
      case (reg_addr)
        `MESR_OFF_CTRL:
        begin
          tx_enable_d = reg_wdata[`MESR_BIT_TRANSMIT_ENABLE]; // see [RQ1]
          rx_enable_d = reg_wdata[`MESR_BIT_RECEIVE_ENABLE]; // see [RQ2]
        end
        `MESR_OFF_ADDR_HI:
        begin
          if (host_ok)
          begin
            addr_hi_d = reg_wdata[15:0]; // see [RQ3]
          end
        end
        `MESR_OFF_ADDR_LO:
        begin
          if (host_ok)
          begin
            addr_lo_d = reg_wdata; // see [RQ6]
          end
        end
        default:
        begin
          // unmapped writes dropped; a loader byte must not be undone
        end
      endcase
    end
  end

  // register address and control
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      addr_hi_q <= `MESR_RST_ADDR_HI; // see [RQ4]
      addr_lo_q <= `MESR_RST_ADDR_LO; // see [RQ7]
      tx_enable_q <= 1'b0;
      rx_enable_q <= 1'b0;
    end
    else
    begin
      addr_hi_q <= addr_hi_d;
      addr_lo_q <= addr_lo_d;
      tx_enable_q <= tx_enable_d;
      rx_enable_q <= rx_enable_d;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------

  // read data only in the cycle after the strobe, else zero
  always_comb
  begin
    reg_rdata_d = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        `MESR_OFF_STATUS:
        begin
          reg_rdata_d[`MESR_BIT_INIT_DONE] = (state_q == MESR_ST_RUN);
          reg_rdata_d[`MESR_BIT_EE_LOADED] = ee_loaded_q;
        end
        `MESR_OFF_CTRL:
        begin
          reg_rdata_d[`MESR_BIT_TRANSMIT_ENABLE] = tx_enable_q;
          reg_rdata_d[`MESR_BIT_RECEIVE_ENABLE] = rx_enable_q;
        end
        `MESR_OFF_ADDR_HI: reg_rdata_d = {16'h0000, addr_hi_q}; // see [RQ4]
        `MESR_OFF_ADDR_LO: reg_rdata_d = addr_lo_q; // see [RQ6]
        default: reg_rdata_d = '0; // unmapped reads zero
      endcase
    end
  end

  // register read data
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rdata_q <= '0;
    end
    else
    begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // mac datapath use of enables and address
  // ----------------------------------------------------------------

  // gating and matching; the address feeds only the da match and station_addr_q
  // logic, the general filter never sees it (see [RQ11])
  always_comb
  begin
    tx_take_d = tx_frame_req && tx_enable_q; // see [RQ1]
    rx_accept_d = rx_frame_valid && rx_enable_q; // see [RQ2]
    // first wire byte sits in low bits 7:0 of both vectors
    station_addr_d = {addr_hi_q, addr_lo_q}; // see [RQ15]
    // no match while the address is still undefined
    da_match_d = rx_da_valid && (state_q == MESR_ST_RUN)
                 && (rx_da == station_addr_d); // see [RQ10]
    addr_valid_d = (state_q == MESR_ST_RUN); // see [RQ12]
  end

  // register datapath outputs
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tx_take_q <= 1'b0;
      rx_accept_q <= 1'b0;
      da_match_q <= 1'b0;
      addr_valid_q <= 1'b0;
      station_addr_q <= {`MESR_RST_ADDR_HI, `MESR_RST_ADDR_LO};
    end
    else
    begin
      tx_take_q <= tx_take_d;
      rx_accept_q <= rx_accept_d;
      da_match_q <= da_match_d;
      addr_valid_q <= addr_valid_d;
      station_addr_q <= station_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_tx_gate: assert property ( // see [RQ1]
    tx_frame_req && !tx_enable_q |=> !tx_take_q)
    else $error("frame taken with transmitter disabled");

  chk_rx_gate: assert property ( // see [RQ2]
    rx_frame_valid && !rx_enable_q |=> !rx_accept_q)
    else $error("frame accepted with receiver disabled");

  chk_hi_readback: assert property ( // see [RQ3]
    reg_rd && reg_addr == `MESR_OFF_ADDR_HI
    |=> reg_rdata_q == {16'h0000, $past(addr_hi_q)})
    else $error("high address read mismatch");

  chk_hi_reset_val: assert property ( // see [RQ4]
    @(posedge ref_clk) disable iff (1'b0)
    srst |=> addr_hi_q == 16'hffff && reg_rdata_q == 32'h0)
    else $error("high address reset value wrong");

  chk_lo_reset_val: assert property ( // see [RQ7]
    @(posedge ref_clk) disable iff (1'b0)
    srst |=> addr_lo_q == 32'h0fffffff)
    else $error("low address reset value wrong");

  chk_hi_preload: assert property ( // see [RQ5]
    load_ok && ee_byte_addr == 8'h06
    |=> addr_hi_q[15:8] == $past(ee_byte_data))
    else $error("eeprom byte 06h not in high bits 15:8");

  chk_lo_preload: assert property ( // see [RQ8]
    load_ok && ee_byte_addr == 8'h04
    |=> addr_lo_q[31:24] == $past(ee_byte_data))
    else $error("eeprom byte 04h not in low bits 31:24");

  chk_mid_preload: assert property ( // see [RQ14]
    load_ok && ee_byte_addr == 8'h02
    |=> addr_lo_q[15:8] == $past(ee_byte_data))
    else $error("eeprom byte 02h not in low bits 15:8");

  chk_blank_eeprom: assert property ( // see [RQ9]
    !ee_programmed && !reg_wr |=> $stable(addr_lo_q) && $stable(addr_hi_q))
    else $error("address changed without programmed eeprom");

  chk_lo_write: assert property ( // see [RQ6]
    reg_wr && host_ok && reg_addr == `MESR_OFF_ADDR_LO && !load_ok
    |=> addr_lo_q == $past(reg_wdata)
    ##1 station_addr_q[31:0] == $past(addr_lo_q))
    else $error("low address write lost");

  chk_init_block: assert property ( // see [RQ13]
    reg_wr && !host_ok && reg_addr == `MESR_OFF_ADDR_HI && !load_ok
    |=> $stable(addr_hi_q))
    else $error("host wrote address during init");

  chk_match_valid: assert property ( // see [RQ12]
    da_match_q |-> addr_valid_q && $past(rx_da_valid))
    else $error("da match before address valid");

  cov_preload: cover property (load_ok ##[1:20] ee_load_done);
  cov_host_addr: cover property (
    host_ok && reg_wr && reg_addr == `MESR_OFF_ADDR_LO);
  cov_da_match: cover property (da_match_q);
  cov_tx_take: cover property (tx_take_q ##1 rx_accept_q);

endmodule

// File: dv/mesr_ee_model.sv
// eeprom loader stand-in that streams the six station address bytes
`timescale 1ns/1ps

module mesr_ee_model
(
  input wire logic ref_clk,
  input wire logic start,
  input wire logic prog,
  input wire logic [47:0] image,
  output logic ee_programmed,
  output logic ee_byte_wr,
  output logic [7:0] ee_byte_addr,
  output logic [7:0] ee_byte_data,
  output logic ee_load_done
);
  // step 0 idle, 1..6 byte address, 7 finish pulse
  logic [2:0] step_q;

  initial
  begin
    step_q = 3'h0;
    ee_programmed = 1'b0;
    ee_byte_wr = 1'b0;
    ee_byte_addr = 8'h00;
    ee_byte_data = 8'h00;
    ee_load_done = 1'b0;
  end

  // bytes stream even when unprogrammed, so the bank must gate them
  always @(posedge ref_clk)
  begin
    ee_programmed <= prog;
    ee_byte_wr <= 1'b0;
    ee_load_done <= 1'b0;
    // idle lines flip so a stale byte never looks like a fresh one
    ee_byte_addr <= ~ee_byte_addr;
    ee_byte_data <= ~ee_byte_data;
    if (start)
      step_q <= 3'h1;
    else if (step_q == 3'h7)
    begin
      ee_load_done <= 1'b1;
      step_q <= 3'h0;
    end
    else if (step_q != 3'h0)
    begin
      ee_byte_wr <= 1'b1;
      ee_byte_addr <= {5'h00, step_q};
      ee_byte_data <= image[8 * (int'(step_q) - 1) +: 8];
      step_q <= step_q + 3'h1;
    end
  end
endmodule

// File: dv/mesr_regs_tb_top.sv
// self-checking bench for the station address register bank
`timescale 1ns/1ps
`include "mesr_consts.svh"

module mesr_regs_tb_top
  import mesr_pkg::*;
  ;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  mesr_addr_t reg_addr = 8'h00;
  mesr_word_t reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  mesr_word_t reg_rdata_q;
  logic ee_programmed, ee_byte_wr, ee_load_done;
  logic [7:0] ee_byte_addr, ee_byte_data;
  logic ee_start = 1'b0;
  logic ee_prog = 1'b0;
  logic [47:0] ee_image = 48'h000000000000;
  logic tx_frame_req = 1'b0;
  logic rx_frame_valid = 1'b0;
  logic rx_da_valid = 1'b0;
  logic [47:0] rx_da = 48'h000000000000;
  logic tx_enable_q, rx_enable_q, tx_take_q, rx_accept_q;
  logic da_match_q, addr_valid_q;
  logic [47:0] station_addr_q;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  // 10 MHz reference clock
  always #50 ref_clk = ~ref_clk;

  mesr_regs dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .ee_programmed, .ee_byte_wr, .ee_byte_addr,
    .ee_byte_data, .ee_load_done, .tx_frame_req, .rx_frame_valid,
    .rx_da_valid, .rx_da, .tx_enable_q, .rx_enable_q, .tx_take_q,
    .rx_accept_q, .da_match_q, .addr_valid_q, .station_addr_q);

  mesr_ee_model ee (.ref_clk, .start(ee_start), .prog(ee_prog),
    .image(ee_image), .ee_programmed, .ee_byte_wr, .ee_byte_addr,
    .ee_byte_data, .ee_load_done);

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_w(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    chk_w({47'h0, got}, {47'h0, exp});
  endtask

  // one-cycle write strobe
  task automatic wr(input mesr_addr_t a, input mesr_word_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input mesr_addr_t a, input mesr_word_t exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk_w({16'h0, reg_rdata_q}, {16'h0, exp});
  endtask

  task automatic do_reset(input logic prog);
    srst <= 1'b1;
    ee_prog <= prog;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
  endtask

  // start the loader and wait, bounded, for the address to be defined
  task automatic load_ee;
    int n;
    n = 0;
    @(posedge ref_clk);
    ee_start <= 1'b1;
    @(posedge ref_clk);
    ee_start <= 1'b0;
    while (addr_valid_q !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    #1;
  endtask

  // one cycle of received destination address, match one cycle late
  task automatic da_chk(input logic [47:0] da, input logic exp);
    @(posedge ref_clk);
    rx_da <= da;
    rx_da_valid <= 1'b1;
    @(posedge ref_clk);
    rx_da_valid <= 1'b0;
    #1;
    chk_b(da_match_q, exp);
  endtask

  task automatic en_chk(input mesr_word_t d, input logic tx,
    input logic rx);
    wr(`MESR_OFF_CTRL, d);
    rd_chk(`MESR_OFF_CTRL, {28'h0, tx, rx, 2'b00});
    chk_b(tx_enable_q, tx);
    chk_b(rx_enable_q, rx);
    chk_b(tx_take_q, tx);
    chk_b(rx_accept_q, rx);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_init_state;
    chk_b(addr_valid_q, 1'b0);
    rd_chk(`MESR_OFF_CTRL, 32'h0);
    rd_chk(`MESR_OFF_ADDR_HI, 32'h0000ffff);
    rd_chk(`MESR_OFF_ADDR_LO, 32'h0fffffff);
    chk_w(station_addr_q, 48'hffff0fffffff);
    // host write before init ends has to be dropped
    wr(`MESR_OFF_ADDR_LO, 32'h12345678);
    rd_chk(`MESR_OFF_ADDR_LO, 32'h0fffffff);
    rd_chk(8'h3c, 32'h0);
    da_chk(48'hffff0fffffff, 1'b0);
  endtask

  task automatic t_preload;
    ee_image <= 48'h665544332211;
    load_ee();
    chk_b(addr_valid_q, 1'b1);
    rd_chk(`MESR_OFF_ADDR_HI, 32'h00006655);
    rd_chk(`MESR_OFF_ADDR_LO, 32'h44332211);
    rd_chk(`MESR_OFF_STATUS, 32'h3);
    chk_w(station_addr_q, 48'h665544332211);
    da_chk(48'h665544332211, 1'b1);
    da_chk(48'h112233445566, 1'b0);
  endtask

  // writes only after init, as the host must
  task automatic t_host_write;
    wr(`MESR_OFF_ADDR_HI, 32'hffffa5c3);
    wr(`MESR_OFF_ADDR_LO, 32'h89abcdef);
    rd_chk(`MESR_OFF_ADDR_HI, 32'h0000a5c3);
    rd_chk(`MESR_OFF_ADDR_LO, 32'h89abcdef);
    chk_w(station_addr_q, 48'ha5c389abcdef);
    da_chk(48'ha5c389abcdef, 1'b1);
    da_chk(48'ha5c389abcdee, 1'b0);
  endtask

  // frames waiting throughout; gating follows the enable bits only
  task automatic t_enables;
    @(posedge ref_clk);
    tx_frame_req <= 1'b1;
    rx_frame_valid <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk_b(tx_take_q, 1'b0);
    chk_b(rx_accept_q, 1'b0);
    en_chk(32'h00000008, 1'b1, 1'b0);
    en_chk(32'h00000004, 1'b0, 1'b1);
    en_chk(32'hfffffff3, 1'b0, 1'b0);
    en_chk(32'hffffffff, 1'b1, 1'b1);
    @(posedge ref_clk);
    tx_frame_req <= 1'b0;
    rx_frame_valid <= 1'b0;
  endtask

  // second reset, blank eeprom: streamed bytes must not land
  task automatic t_unprogrammed;
    // raise reset on a clock edge, as every other input
    @(posedge ref_clk);
    do_reset(1'b0);
    chk_b(tx_enable_q, 1'b0);
    chk_b(rx_enable_q, 1'b0);
    ee_image <= 48'h0a0b0c0d0e0f;
    load_ee();
    chk_b(addr_valid_q, 1'b1);
    rd_chk(`MESR_OFF_ADDR_HI, 32'h0000ffff);
    rd_chk(`MESR_OFF_ADDR_LO, 32'h0fffffff);
    rd_chk(`MESR_OFF_STATUS, 32'h1);
  endtask

  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    do_reset(1'b1);
    t_init_state();
    t_preload();
    t_host_write();
    t_enables();
    t_unprogrammed();
    summarize();
  end
endmodule
